// ==== baro_conversion_regs.sv ====
// Purpose: register bank and conversion sequencer of the barometric sensor
// Assumes: serial framing decoded outside into a byte-wide register port on clk
// Notes: adc_done, adc_result and fault_in come from logic on clk; pins are synced
`timescale 1ns/100ps
module baro_conversion_regs #(
	parameter logic [31:0] SLEEP_STEP_CYCLES = 32'(baro_pkg::SLEEP_STEP_CYC)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] otp_part_code,
	input wire logic [7:0] otp_sys_config,
	input wire logic [7:0] otp_pres_config,
	input wire logic [7:0] otp_temp_config,
	input wire logic iface_sel_pin,
	input wire logic addr_sel_pin,
	output logic spi_selected,
	output logic [6:0] i2c_address,
	output logic spi_four_wire,
	output logic spi_lsb_first,
	output logic adc_start,
	output logic adc_pressure,
	input wire logic adc_done,
	input wire logic [23:0] adc_result,
	input wire logic [3:0] fault_in,
	output logic [7:0] adc_gain,
	output logic [15:0] adc_osr,
	output logic raw_output,
	output logic unipolar_output,
	output logic diag_enable,
	output logic regulator_high,
	output logic [6:0] pt_ratio_count,
	output logic otp_program_mode,
	output logic busy
);
	typedef struct packed {
		logic ctrl_4w;
		logic ctrl_lsb;
		logic srst;
		logic [3:0] sleep;
		logic sco;
		logic [2:0] mode;
		logic [2:0] conv_mode;
		logic ready;
		logic [3:0] fault;
		logic [23:0] press;
		logic [15:0] temp;
		logic [7:0] part;
		logic [7:0] sys;
		logic [5:0] pcfg;
		logic [5:0] tcfg;
		baro_pkg::conv_state_t state;
		logic adc_start;
		logic [31:0] step_cnt;
		logic [3:0] steps_left;
		logic [7:0] rdata;
		logic sel_s1;
		logic sel_s2;
		logic adr_s1;
		logic adr_s2;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// fresh state: normal registers cleared, configuration reloaded from OTP
	function automatic state_t fresh_state(input logic [7:0] pc, input logic [7:0] sy,
			input logic [7:0] pp, input logic [7:0] tt);
		state_t f;
		f = '0;
		f.state = baro_pkg::CS_IDLE;
		f.part = pc; // R22
		f.sys = sy;
		f.pcfg = pp[5:0];
		f.tcfg = tt[5:0];
		return f;
	endfunction

	// next state of registers, sequencer and pin synchronisers
	always_comb begin
		logic [7:0] rd;
		logic finish;
		logic go_pres;
		rd = baro_pkg::RESET_VAL;
		finish = 1'b0;
		go_pres = 1'b0;
		s_nxt = s_r;
		s_nxt.adc_start = 1'b0;
		s_nxt.sel_s1 = iface_sel_pin;
		s_nxt.sel_s2 = s_r.sel_s1;
		s_nxt.adr_s1 = addr_sel_pin;
		s_nxt.adr_s2 = s_r.adr_s1;
		// read mux, unmapped addresses read zero
		unique case (reg_addr)
			baro_pkg::A_CTRL: begin
				rd[baro_pkg::CTRL_4W] = s_r.ctrl_4w;
				rd[baro_pkg::CTRL_LSB] = s_r.ctrl_lsb;
				rd[baro_pkg::CTRL_SRST] = s_r.srst;
				rd[baro_pkg::CTRL_4W_M] = s_r.ctrl_4w;
				rd[baro_pkg::CTRL_LSB_M] = s_r.ctrl_lsb;
				rd[baro_pkg::CTRL_SRST_M] = s_r.srst;
			end
			baro_pkg::A_PART: rd = s_r.part; // R4
			baro_pkg::A_STAT: begin
				rd[baro_pkg::STAT_READY] = s_r.ready; // R5
				rd[baro_pkg::STAT_FAULT_LSB +: 4] = s_r.fault; // R6
			end
			baro_pkg::A_P_HI: rd = s_r.press[23:16]; // R9
			baro_pkg::A_P_MID: rd = s_r.press[15:8]; // R9
			baro_pkg::A_P_LO: rd = s_r.press[7:0]; // R9
			baro_pkg::A_T_HI: rd = s_r.temp[15:8]; // R10
			baro_pkg::A_T_LO: rd = s_r.temp[7:0]; // R10
			baro_pkg::A_CMD: rd = {s_r.sleep, s_r.sco, s_r.mode};
			baro_pkg::A_PART_ST: rd = s_r.part;
			baro_pkg::A_SYS: rd = s_r.sys;
			baro_pkg::A_PCFG: rd = {baro_pkg::PCFG_FIXED, s_r.pcfg};
			baro_pkg::A_TCFG: rd = {baro_pkg::TCFG_FIXED, s_r.tcfg};
			default: rd = baro_pkg::RESET_VAL;
		endcase
		if (reg_rd) begin
			s_nxt.rdata = rd;
		end
		// register writes; the part code mirror is read only
		if (reg_wr) begin
			unique case (reg_addr)
				baro_pkg::A_CTRL: begin
					s_nxt.ctrl_4w = reg_wdata[baro_pkg::CTRL_4W] |
						reg_wdata[baro_pkg::CTRL_4W_M]; // R2
					s_nxt.ctrl_lsb = reg_wdata[baro_pkg::CTRL_LSB] |
						reg_wdata[baro_pkg::CTRL_LSB_M]; // R3
					s_nxt.srst = reg_wdata[baro_pkg::CTRL_SRST] |
						reg_wdata[baro_pkg::CTRL_SRST_M]; // R1
				end
				baro_pkg::A_CMD: begin
					s_nxt.sleep = reg_wdata[baro_pkg::CMD_SLEEP_LSB +: 4];
					s_nxt.mode = reg_wdata[baro_pkg::CMD_MODE_LSB +: 3];
					if (!reg_wdata[baro_pkg::CMD_SCO]) begin
						s_nxt.sco = 1'b0; // stops periodic after the running conversion pair, or at once during the wait
					end else if (s_r.state == baro_pkg::CS_IDLE &&
							s_nxt.mode <= baro_pkg::MODE_PERIODIC) begin
						s_nxt.sco = 1'b1; // R14
						s_nxt.ready = 1'b0; // R24
						s_nxt.conv_mode = s_nxt.mode; // R12
						s_nxt.adc_start = 1'b1;
						s_nxt.state = (s_nxt.mode == baro_pkg::MODE_PRES) ?
							baro_pkg::CS_PRES : baro_pkg::CS_TEMP;
					end
				end
				baro_pkg::A_PART_ST: s_nxt.part = reg_wdata;
				baro_pkg::A_SYS: s_nxt.sys = reg_wdata;
				baro_pkg::A_PCFG: s_nxt.pcfg = reg_wdata[5:0];
				baro_pkg::A_TCFG: s_nxt.tcfg = reg_wdata[5:0];
				default: ;
			endcase
		end
		// conversion sequencer
		unique case (s_r.state)
			baro_pkg::CS_IDLE: ;
			baro_pkg::CS_TEMP: if (adc_done) begin
				s_nxt.temp = adc_result[15:0]; // R10
				s_nxt.fault = s_r.sys[baro_pkg::SYS_DIAG] ? fault_in : 4'h0; // R7
				if (s_r.conv_mode == baro_pkg::MODE_TEMP) begin
					finish = 1'b1; // R12
				end else begin
					go_pres = 1'b1; // R12
				end
			end
			baro_pkg::CS_PRES: if (adc_done) begin
				s_nxt.press = adc_result; // R8
				s_nxt.fault = s_r.sys[baro_pkg::SYS_DIAG] ? fault_in : 4'h0; // R7
				if (s_r.conv_mode == baro_pkg::MODE_PERIODIC && s_nxt.sco) begin
					s_nxt.ready = 1'b1; // R5
					if (s_r.sleep == 4'h0) begin
						s_nxt.adc_start = 1'b1; // R11
						s_nxt.state = baro_pkg::CS_TEMP;
					end else begin
						s_nxt.state = baro_pkg::CS_SLEEP;
						s_nxt.step_cnt = 32'h0;
						s_nxt.steps_left = s_r.sleep; // R11
					end
				end else begin
					finish = 1'b1;
				end
			end
			baro_pkg::CS_SLEEP: begin
				if (!s_nxt.sco) begin
					s_nxt.state = baro_pkg::CS_IDLE;
				end else if (s_r.step_cnt == SLEEP_STEP_CYCLES - 32'h1) begin
					s_nxt.step_cnt = 32'h0;
					s_nxt.steps_left = s_r.steps_left - 4'h1;
					if (s_r.steps_left == 4'h1) begin
						s_nxt.adc_start = 1'b1; // R11
						s_nxt.state = baro_pkg::CS_TEMP;
					end
				end else begin
					s_nxt.step_cnt = s_r.step_cnt + 32'h1;
				end
			end
		endcase
		if (go_pres) begin
			s_nxt.adc_start = 1'b1;
			s_nxt.state = baro_pkg::CS_PRES;
		end
		if (finish) begin
			s_nxt.ready = 1'b1; // R5
			s_nxt.sco = 1'b0; // R14
			s_nxt.state = baro_pkg::CS_IDLE;
		end
		// soft reset acts one cycle after the write, then drops itself
		if (s_r.srst) begin
			s_nxt = fresh_state(otp_part_code, otp_sys_config, otp_pres_config,
				otp_temp_config); // R1
			s_nxt.sel_s1 = s_r.sel_s1;
			s_nxt.sel_s2 = s_r.sel_s2;
			s_nxt.adr_s1 = s_r.adr_s1;
			s_nxt.adr_s2 = s_r.adr_s2;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= fresh_state(otp_part_code, otp_sys_config, otp_pres_config,
				otp_temp_config); // R22
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs towards port logic and analog front end
	assign reg_rdata = s_r.rdata;
	assign spi_selected = ~s_r.sel_s2; // R21
	assign i2c_address = {baro_pkg::I2C_ADDR_BASE, s_r.adr_s2}; // R23
	assign spi_four_wire = s_r.ctrl_4w; // R2
	assign spi_lsb_first = s_r.ctrl_lsb; // R3
	assign adc_start = s_r.adc_start;
	assign adc_pressure = (s_r.state == baro_pkg::CS_PRES);
	assign adc_gain = adc_pressure ?
		8'(8'h01 << s_r.pcfg[baro_pkg::CFG_GAIN_LSB +: 3]) :
		8'(8'h01 << s_r.tcfg[baro_pkg::CFG_GAIN_LSB +: 3]); // R18 R20
	assign adc_osr = adc_pressure ?
		baro_pkg::osr_ratio(s_r.pcfg[baro_pkg::CFG_OSR_LSB +: 3]) :
		baro_pkg::osr_ratio(s_r.tcfg[baro_pkg::CFG_OSR_LSB +: 3]); // R19 R20
	assign raw_output = s_r.sys[baro_pkg::SYS_RAW] &&
		(s_r.conv_mode == baro_pkg::MODE_TEMP ||
		s_r.conv_mode == baro_pkg::MODE_PRES); // R17
	assign unipolar_output = s_r.sys[baro_pkg::SYS_UNI] && raw_output; // R16
	assign diag_enable = s_r.sys[baro_pkg::SYS_DIAG]; // R7
	assign regulator_high = s_r.sys[baro_pkg::SYS_REG];
	assign pt_ratio_count = baro_pkg::pt_count(s_r.sys[baro_pkg::SYS_RATIO_LSB +: 2]); // R15
	assign otp_program_mode = (s_r.mode == baro_pkg::MODE_OTP); // R13
	assign busy = (s_r.state != baro_pkg::CS_IDLE);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence srst_write;
		reg_wr && reg_addr == baro_pkg::A_CTRL &&
			(reg_wdata[baro_pkg::CTRL_SRST] || reg_wdata[baro_pkg::CTRL_SRST_M]);
	endsequence
	sequence srst_done;
		s_r.srst ##1 (!s_r.srst && !busy && !s_r.ready && s_r.press == 24'h0);
	endsequence
	chk_softrst_self_clear: assert property (srst_write |=> srst_done) // R1
		else $error("soft reset did not clear registers and drop");

	chk_four_wire_sel: assert property (reg_wr && reg_addr == baro_pkg::A_CTRL && !s_r.srst
		|=> spi_four_wire == ($past(reg_wdata[0]) | $past(reg_wdata[7]))) // R2
		else $error("four-wire select does not follow write");

	chk_bit_order_sel: assert property (reg_wr && reg_addr == baro_pkg::A_CTRL && !s_r.srst
		|=> spi_lsb_first == ($past(reg_wdata[1]) | $past(reg_wdata[6]))) // R3
		else $error("bit order select does not follow write");

	chk_part_code_mirror: assert property (reg_rd && reg_addr == baro_pkg::A_PART && !s_r.srst
		|=> reg_rdata == $past(s_r.part)) // R4
		else $error("part code readback differs from store");

	chk_ready_after_done: assert property (s_r.state == baro_pkg::CS_PRES && adc_done &&
		!s_r.srst |=> s_r.ready && s_r.press == $past(adc_result)) // R5
		else $error("ready flag or pressure missing after conversion");

	chk_fault_gate_diag: assert property (adc_done && busy && !s_r.srst &&
		!s_r.sys[baro_pkg::SYS_DIAG] |=> s_r.fault == 4'h0) // R7
		else $error("fault bits set with diagnosis off");

	sequence host_start;
		reg_wr && reg_addr == baro_pkg::A_CMD && reg_wdata[baro_pkg::CMD_SCO] &&
			!busy && !s_r.srst && reg_wdata[2:0] <= baro_pkg::MODE_PERIODIC;
	endsequence
	chk_start_clears_rdy: assert property (host_start |=> !s_r.ready && busy && adc_start
		&& s_r.sco) // R24
		else $error("start did not clear ready and launch conversion");

	chk_sco_single_clear: assert property (s_r.state == baro_pkg::CS_TEMP && adc_done &&
		s_r.conv_mode == baro_pkg::MODE_TEMP && !s_r.srst |=> !s_r.sco ##1 !busy) // R14
		else $error("start bit stayed set after single conversion");

	chk_periodic_holds_sco: assert property (s_r.state == baro_pkg::CS_SLEEP && s_r.sco
		&& !reg_wr && !s_r.srst |=> s_r.sco) // R14
		else $error("start bit dropped during periodic wait");

	chk_raw_single_only: assert property (raw_output |-> s_r.conv_mode <= baro_pkg::MODE_PRES
		&& !(unipolar_output && !raw_output)) // R17
		else $error("raw output outside single conversion");

	chk_iface_sel_sync: assert property (iface_sel_pin ##1 iface_sel_pin ##1 1'b1
		|=> !spi_selected) // R21
		else $error("I2C not selected for high select pin");
endmodule

// ==== baro_pkg.sv ====
// Purpose: shared constants and types for the pressure/temperature register bank
// Assumes: 8-bit register port, 100 MHz core clock
// Notes: field positions and timing counts live here only
//
// Functional notes
// R1: writing soft reset clears all registers once, then the bit drops by itself
// R2: four-wire bit set selects four-wire SPI, clear selects three-wire SPI
// R3: bit order bit set sends SPI least significant bit first, clear MSB first
// R4: part code reads at 0x01, is not writable there, mirrors store at 0xa4
// R5: result ready flag rises once a conversion completed and data is readable
// R6: fault bits: 3 pos to supply, 2 pos to ground, 1 neg to supply, 0 neg to ground
// R7: fault check enable bit turns on the diagnosis that fills the fault bits
// R8: pressure result is raw data or calibrated data per the raw output select
// R9: pressure bytes 23..16 at 0x06, 15..8 at 0x07, 7..0 at 0x08, reset zero
// R10: temperature upper byte at 0x09, lower byte at 0x0a, 1/256 degree per count
// R11: periodic wait is field times 62.5 ms, used only in periodic mode
// R12: mode 000 temp, 001 pressure, 010 temp then pressure, 011 periodic combined
// R13: mode 100 is OTP programming; host selects it before programming banks
// R14: start bit begins a conversion, clears at the end except in periodic mode
// R15: pressure-per-temperature field 00 64, 01 32, 10 16, 11 one
// R16: unipolar bit selects unipolar ADC format, applies only with raw output on
// R17: raw output select applies only to single temperature or pressure conversions
// R18: pressure gain is two to the power of the three-bit field
// R19: pressure oversampling code maps 1024,2048,4096,8192,256,512,16384,32768
// R20: temperature channel has own gain and oversampling fields, same encodings
// R21: interface select pin low picks SPI, high or floating picks I2C
// R22: upper configuration registers load their defaults from the OTP banks
// R23: I2C address is 110110 followed by the address select pin level
// R24: result ready flag clears when the host starts a new conversion
package baro_pkg;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PART = 8'h01;
	localparam logic [7:0] A_STAT = 8'h02;
	localparam logic [7:0] A_P_HI = 8'h06;
	localparam logic [7:0] A_P_MID = 8'h07;
	localparam logic [7:0] A_P_LO = 8'h08;
	localparam logic [7:0] A_T_HI = 8'h09;
	localparam logic [7:0] A_T_LO = 8'h0a;
	localparam logic [7:0] A_CMD = 8'h30;
	localparam logic [7:0] A_PART_ST = 8'ha4;
	localparam logic [7:0] A_SYS = 8'ha5;
	localparam logic [7:0] A_PCFG = 8'ha6;
	localparam logic [7:0] A_TCFG = 8'ha7;
	localparam logic [7:0] RESET_VAL = 8'h00;
	// control register: low bits and their mirror in the high bits
	localparam int CTRL_4W = 0;
	localparam int CTRL_LSB = 1;
	localparam int CTRL_SRST = 2;
	localparam int CTRL_SRST_M = 5;
	localparam int CTRL_LSB_M = 6;
	localparam int CTRL_4W_M = 7;
	// status register
	localparam int STAT_READY = 0;
	localparam int STAT_FAULT_LSB = 4;
	// command register
	localparam int CMD_MODE_LSB = 0;
	localparam int CMD_SCO = 3;
	localparam int CMD_SLEEP_LSB = 4;
	localparam logic [2:0] MODE_TEMP = 3'h0;
	localparam logic [2:0] MODE_PRES = 3'h1;
	localparam logic [2:0] MODE_COMB = 3'h2;
	localparam logic [2:0] MODE_PERIODIC = 3'h3;
	localparam logic [2:0] MODE_OTP = 3'h4;
	// system configuration
	localparam int SYS_DIAG = 0;
	localparam int SYS_RAW = 1;
	localparam int SYS_UNI = 2;
	localparam int SYS_REG = 3;
	localparam int SYS_RATIO_LSB = 4;
	// channel configuration
	localparam int CFG_OSR_LSB = 0;
	localparam int CFG_GAIN_LSB = 3;
	localparam logic [1:0] PCFG_FIXED = 2'h1;
	localparam logic [1:0] TCFG_FIXED = 2'h3;
	// I2C address upper six bits, 110110b
	localparam logic [5:0] I2C_ADDR_BASE = 6'h36;
	// periodic wait step
	localparam int SLEEP_STEP_US = 62500;
	localparam int CLK_MHZ = 100;
	localparam int SLEEP_STEP_CYC = SLEEP_STEP_US * CLK_MHZ;

	typedef enum logic [1:0] {CS_IDLE, CS_TEMP, CS_PRES, CS_SLEEP} conv_state_t;

	// oversampling ratio from its three-bit code
	function automatic logic [15:0] osr_ratio(input logic [2:0] code);
		unique case (code)
			3'h0: osr_ratio = 16'h0400;
			3'h1: osr_ratio = 16'h0800;
			3'h2: osr_ratio = 16'h1000;
			3'h3: osr_ratio = 16'h2000;
			3'h4: osr_ratio = 16'h0100;
			3'h5: osr_ratio = 16'h0200;
			3'h6: osr_ratio = 16'h4000;
			3'h7: osr_ratio = 16'h8000;
		endcase
	endfunction

	// pressure conversions per temperature conversion
	function automatic logic [6:0] pt_count(input logic [1:0] code);
		unique case (code)
			2'h0: pt_count = 7'h40;
			2'h1: pt_count = 7'h20;
			2'h2: pt_count = 7'h10;
			2'h3: pt_count = 7'h01;
		endcase
	endfunction
endpackage

// ==== adc_front_model.sv ====
// Purpose: front-end converter model answering conversion starts of the register bank
// Assumes: start is a one-cycle pulse on clk, delay_cyc is at least one
// Notes: result and fault lines toggle every cycle when no result is offered
`timescale 1ns/100ps
module adc_front_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic adc_start,
	input wire logic adc_pressure,
	input wire logic [7:0] delay_cyc,
	input wire logic [23:0] pres_val,
	input wire logic [15:0] temp_val,
	input wire logic [3:0] fault_val,
	output logic adc_done,
	output logic [23:0] adc_result,
	output logic [3:0] fault_in
);
	logic [7:0] cnt_r;
	logic chan_r;
	// count down the conversion time, then offer one result for one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 8'h00;
			chan_r <= 1'b0;
			adc_done <= 1'b0;
			adc_result <= 24'h000000;
			fault_in <= 4'h0;
		end else begin
			adc_done <= 1'b0;
			adc_result <= ~adc_result; // stale data never looks valid
			fault_in <= ~fault_in;
			if (adc_start) begin
				cnt_r <= delay_cyc;
				chan_r <= adc_pressure;
			end else if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					adc_done <= 1'b1;
					adc_result <= chan_r ? pres_val : {8'h00, temp_val};
					fault_in <= fault_val;
				end
			end
		end
	end
endmodule

// ==== tb_baro_conversion_regs.sv ====
// Purpose: self-checking bench of the pressure/temperature register bank
// Assumes: register port strobes driven at the falling edge, one access per two cycles
// Notes: read results are queued by the driver and compared by a watcher
`timescale 1ns/100ps
module tb_baro_conversion_regs;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dly = 8'h03;
	logic [7:0] otp_part_code, otp_sys_config, otp_pres_config, otp_temp_config;
	logic iface_sel_pin = 1'b1, addr_sel_pin = 1'b0, spi_selected, spi_four_wire, spi_lsb_first;
	logic adc_start, adc_pressure, adc_done, raw_output, unipolar_output, diag_enable;
	logic otp_program_mode, busy;
	logic [6:0] i2c_address, pt_ratio_count;
	logic [23:0] adc_result, pv = 24'h000000;
	logic [15:0] adc_osr, tv = 16'h0000;
	logic [7:0] adc_gain;
	logic [3:0] fault_in, fv = 4'h0, fprev = 4'h0;
	logic [7:0] exp_q[$], adr_q[$];
	logic [15:0] osr_tab [8] = '{16'h0400, 16'h0800, 16'h1000, 16'h2000,
		16'h0100, 16'h0200, 16'h4000, 16'h8000};
	logic [6:0] ratio_tab [4] = '{7'h40, 7'h20, 7'h10, 7'h01};
	logic [7:0] sys_tab [3] = '{8'h01, 8'h06, 8'h07};
	int error_cnt = 0, n_compared = 0, n_start = 0, cyc = 0, t_prev = 0, t_last = 0, ns0;

	baro_conversion_regs #(.SLEEP_STEP_CYCLES(32'h14)) DUT (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .otp_part_code(otp_part_code), .otp_sys_config(otp_sys_config),
		.otp_pres_config(otp_pres_config), .otp_temp_config(otp_temp_config),
		.iface_sel_pin(iface_sel_pin), .addr_sel_pin(addr_sel_pin), .spi_selected(spi_selected),
		.i2c_address(i2c_address), .spi_four_wire(spi_four_wire), .spi_lsb_first(spi_lsb_first),
		.adc_start(adc_start), .adc_pressure(adc_pressure), .adc_done(adc_done),
		.adc_result(adc_result), .fault_in(fault_in), .adc_gain(adc_gain), .adc_osr(adc_osr),
		.raw_output(raw_output), .unipolar_output(unipolar_output), .diag_enable(diag_enable),
		.regulator_high(), .pt_ratio_count(pt_ratio_count),
		.otp_program_mode(otp_program_mode), .busy(busy));

	adc_front_model front (.clk(clk), .rst(rst), .adc_start(adc_start),
		.adc_pressure(adc_pressure), .delay_cyc(dly), .pres_val(pv), .temp_val(tv),
		.fault_val(fv), .adc_done(adc_done), .adc_result(adc_result), .fault_in(fault_in));

	// clock generation
	always #5 clk = ~clk;

	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// print the counts and the verdict
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// register write, strobe held for one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask

	// register read, expected value noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		adr_q.push_back(a);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
	endtask

	// bounded waits on the sequencer
	task automatic wait_idle();
		for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
		chk("busy", 32'(busy), 32'h0);
	endtask
	task automatic wait_starts(input int n);
		for (int i = 0; i < 400 && n_start < n; i++) @(negedge clk);
		chk("starts", n_start, n);
	endtask

	// watcher: read data and conversion starts
	always @(posedge clk) begin
		rd_d <= reg_rd;
		cyc <= cyc + 1;
		if (adc_start === 1'b1) begin
			n_start <= n_start + 1;
			t_prev <= t_last;
			t_last <= cyc;
		end
	end
	always @(negedge clk) begin
		if (rd_d && exp_q.size() > 0)
			chk($sformatf("reg_%h", adr_q.pop_front()), 32'(reg_rdata), 32'(exp_q.pop_front()));
	end

	// watchdog
	initial begin
		#400000;
		error_cnt++;
		$display("ERROR watchdog expected finish seen timeout");
		conclude();
	end

	// main sequence
	initial begin
		void'($urandom(96166));
		otp_part_code = 8'($urandom);
		otp_sys_config = 8'($urandom);
		otp_pres_config = 8'($urandom);
		otp_temp_config = 8'($urandom);
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd(8'h00, 8'h00);
		for (int a = 6; a <= 10; a++) rd(8'(a), 8'h00);
		rd(8'h30, 8'h00);
		rd(8'ha4, otp_part_code);
		rd(8'h01, otp_part_code);
		rd(8'ha5, otp_sys_config);
		rd(8'ha6, {2'h1, otp_pres_config[5:0]});
		rd(8'ha7, {2'h3, otp_temp_config[5:0]});
		rd(8'h55, 8'h00);
		wr(8'h01, ~otp_part_code);
		rd(8'h01, otp_part_code);
		wr(8'ha4, 8'h5a);
		rd(8'h01, 8'h5a);
		// interface control bits and their mirror
		wr(8'h00, 8'h03);
		chk("four_wire", 32'(spi_four_wire), 32'h1);
		chk("lsb_first", 32'(spi_lsb_first), 32'h1);
		rd(8'h00, 8'hc3);
		wr(8'h00, 8'h40);
		chk("four_wire", 32'(spi_four_wire), 32'h0);
		rd(8'h00, 8'h42);
		for (int k = 0; k < 2; k++) begin
			iface_sel_pin = k[0];
			addr_sel_pin = ~k[0];
			repeat (4) @(negedge clk);
			chk("spi_sel", 32'(spi_selected), 32'(!k[0]));
			chk("i2c_addr", 32'(i2c_address), {25'h0, 6'h36, ~k[0]});
		end
		// every gain and oversampling code of the temperature channel
		for (int c = 0; c < 64; c += 9) begin
			wr(8'ha7, 8'(c));
			chk("gain", 32'(adc_gain), 32'h1 << c[5:3]);
			chk("osr", 32'(adc_osr), 32'(osr_tab[c[2:0]]));
		end
		for (int r = 0; r < 4; r++) begin
			wr(8'ha5, {2'h0, 2'(r), 4'h1});
			chk("ratio", 32'(pt_ratio_count), 32'(ratio_tab[r]));
			chk("diag", 32'(diag_enable), 32'h1);
		end
		wr(8'ha6, 8'h2c);
		// single temperature, single pressure and combined conversions
		for (int m = 0; m < 3; m++) begin
			pv = 24'($urandom);
			tv = 16'($urandom);
			fv = 4'($urandom);
			dly = 8'(3 + m * 10);
			wr(8'ha5, sys_tab[m]);
			ns0 = n_start;
			wr(8'h30, 8'(8 + m));
			chk("pres_ch", 32'(adc_pressure), 32'(m == 1));
			chk("gain", 32'(adc_gain), (m == 1) ? 32'h20 : 32'h80);
			chk("raw", 32'(raw_output), 32'(m == 1));
			chk("uni", 32'(unipolar_output), 32'(m == 1));
			rd(8'h02, {fprev, 4'h0});
			wait_idle();
			chk("starts", n_start - ns0, (m == 2) ? 2 : 1);
			rd(8'h02, {(m == 1) ? 4'h0 : fv, 4'h1});
			fprev = (m == 1) ? 4'h0 : fv;
			rd(8'h30, 8'(m));
			if (m != 1) rd(8'h09, tv[15:8]);
			if (m != 1) rd(8'h0a, tv[7:0]);
			if (m != 0) for (int b = 0; b < 3; b++) rd(8'(6 + b), pv[23 - 8 * b -: 8]);
		end
		// periodic conversions with a two-step wait
		dly = 8'h03;
		ns0 = n_start;
		wr(8'h30, 8'h2b);
		wait_starts(ns0 + 3);
		chk("sleep_gap", 32'(t_last - t_prev >= 40 && t_last - t_prev <= 52), 32'h1);
		rd(8'h30, 8'h2b);
		rd(8'h02, {fv, 4'h1});
		wr(8'h30, 8'h23);
		wait_idle();
		wr(8'h30, 8'h0c);
		chk("otp_mode", 32'(otp_program_mode), 32'h1);
		chk("busy", 32'(busy), 32'h0);
		// soft reset returns registers to defaults
		wr(8'h00, 8'h04);
		repeat (2) @(negedge clk);
		rd(8'h00, 8'h00);
		rd(8'h30, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h01, otp_part_code);
		chk("lsb_first", 32'(spi_lsb_first), 32'h0);
		chk("otp_mode", 32'(otp_program_mode), 32'h0);
		chk("pending", exp_q.size(), 32'h0);
		conclude();
	end
endmodule
